// >>> dv/term_framer_model.sv
`timescale 1ns/1ns
`default_nettype none
module term_framer_model (
  // link pins toward the encoder
  output logic line_tx_clock,
  output logic positive_rail_in,
  output logic negative_rail_in
);
  // link clock stands low between frames
  initial begin
    line_tx_clock = 1'b0;
    positive_rail_in = 1'b0;
    negative_rail_in = 1'b0;
  end
  // one bit per 800 ns at 37.5% duty; rails settle 200 ns before the rise
  task automatic send(input logic p, input logic n, input logic sr);
    positive_rail_in = p;
    negative_rail_in = sr ? 1'b0 : n; // grounded in single rail
    #200 line_tx_clock = 1'b1;
    #300 line_tx_clock = 1'b0;
    #200 positive_rail_in = ~p; // released rails take the inverse bit, except the negative rail grounded in single rail
    negative_rail_in = sr ? 1'b0 : ~n;
    #100;
  endtask
endmodule
`default_nettype wire

// >>> dv/tx_enc_chk.sv
`timescale 1ns/1ns
`default_nettype none
module tx_enc_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // configuration pins
  input wire logic rail_format_select,
  input wire logic ctl_rail_bit0,
  // shaper side
  input wire logic shaper_ready,
  input wire logic pulse_valid,
  input wire logic pos_pulse,
  input wire logic neg_pulse,
  input wire logic fifo_accept_ready,
  input wire logic single_rail_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // the shaper must never see contradictory flags
  a_flags_exclusive: assert property (!(pos_pulse && neg_pulse))
    else $error("both pulse flags high");
  a_pop_needs_ready: assert property (pulse_valid |-> $past(shaper_ready && ce))
    else $error("symbol without shaper ready");
  a_flags_hold: assert property (!pulse_valid |-> $stable({pos_pulse, neg_pulse}))
    else $error("flags moved without a symbol");
  a_idle_after_reset: assert property ($rose(rst_n) |-> fifo_accept_ready && !pulse_valid)
    else $error("outputs not idle after reset");
  a_full_drains: assert property (
    !fifo_accept_ready && shaper_ready && ce |-> ##[1:3] fifo_accept_ready)
    else $error("full buffer did not drain");
  // pins pass a filter, so allow six settled cycles
  a_single_sel: assert property (
    (rail_format_select || ctl_rail_bit0) [*6] |-> single_rail_active)
    else $error("single rail not selected");
  a_dual_sel: assert property (
    (!rail_format_select && !ctl_rail_bit0) [*6] |-> !single_rail_active)
    else $error("dual rail not selected");
  a_single_cause: assert property (
    $rose(single_rail_active) |-> $past(rail_format_select || ctl_rail_bit0, 2))
    else $error("single rail without a cause");
endmodule
bind tx_rail_format_line_encoder tx_enc_chk tx_enc_chk_inst (.clk_sys, .rst_n, .ce,
  .rail_format_select, .ctl_rail_bit0, .shaper_ready, .pulse_valid, .pos_pulse,
  .neg_pulse, .fifo_accept_ready, .single_rail_active);
`default_nettype wire

// >>> dv/tx_rail_format_line_encoder_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tx_rail_format_line_encoder_tb_top;
  logic clk_sys, rst_n, rail_format_select, ctl_rail_bit0, shaper_ready, ce;
  logic [1:0] rate_sel;
  wire logic line_tx_clock, positive_rail_in, negative_rail_in, pulse_valid;
  wire logic pos_pulse, neg_pulse, tx_clock_50, fifo_accept_ready, single_rail_active;
  logic [1:0] got[$];
  int failures, num_checks, cyc, hi_n, hi_last;

  term_framer_model term_framer_model_inst (.line_tx_clock, .positive_rail_in,
    .negative_rail_in);
  tx_rail_format_line_encoder tx_rail_format_line_encoder_inst (.clk_sys, .rst_n,
    .ce, .line_tx_clock, .positive_rail_in, .negative_rail_in, .rail_format_select,
    .ctl_rail_bit0, .rate_sel, .shaper_ready, .pulse_valid, .pos_pulse, .neg_pulse,
    .tx_clock_50, .fifo_accept_ready, .single_rail_active);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // symbol capture, duty measure and hang guard
  always @(posedge clk_sys) begin
    if (pulse_valid === 1'b1) got.push_back({pos_pulse, neg_pulse});
    hi_n <= (tx_clock_50 === 1'b1) ? hi_n + 1 : 0;
    if (tx_clock_50 !== 1'b1 && hi_n != 0) hi_last <= hi_n;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      conclude();
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks = num_checks + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic conclude();
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // fresh reset per scenario so polarity and parity start known
  task automatic do_reset(input logic fmt, input logic ctl, input logic [1:0] rate);
    @(negedge clk_sys);
    rst_n = 1'b0;
    rail_format_select = fmt;
    ctl_rail_bit0 = ctl;
    rate_sel = rate;
    shaper_ready = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk({7'h00, fifo_accept_ready}, 8'h01);
    rst_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    got.delete();
  endtask

  // reference coder: B flips polarity, V repeats it, parity resets at V
  function automatic void ref_enc(input logic [39:0] b, input int run, ref logic [1:0] q[$]);
    logic last;
    int par, z;
    last = 1'b0;
    par = 0;
    z = 0;
    for (int i = 39; i >= 0; i--) begin
      z = b[i] ? 0 : z + 1;
      if (b[i]) begin
        last = ~last;
        par = par + 1;
      end
      q.push_back(b[i] ? {last, ~last} : 2'b00);
      if (z == run) begin
        if (par % 2 == 0) begin
          last = ~last;
          q[q.size() - run] = {last, ~last};
        end
        q[q.size() - 1] = {last, ~last};
        par = 0;
        z = 0;
      end
    end
  endfunction

  // runs of zeros with odd and even parity before them, ones to flush the pipe
  task automatic single_run(input logic fmt, input logic ctl, input logic [1:0] rate,
                            input int run);
    logic [1:0] q[$];
    logic [39:0] pat;
    pat = 40'h80_4c_00_8f_ff;
    do_reset(fmt, ctl, rate);
    ref_enc(pat, run, q);
    for (int i = 39; i >= 0; i--) term_framer_model_inst.send(pat[i], 1'b0, 1'b1);
    repeat (20) @(negedge clk_sys);
    chk({7'h00, single_rail_active}, 8'h01);
    chk(8'(got.size()), 8'h28);
    for (int k = 4; k < 40; k++) chk({6'h00, got[k]}, {6'h00, q[k - 4]});
    chk(8'(hi_last), 8'h04);
  endtask

  // dual rail passes words through; both rails high is dropped
  task automatic dual_run();
    logic [1:0] w[7];
    w = '{2'h2, 2'h1, 2'h0, 2'h3, 2'h2, 2'h2, 2'h1};
    do_reset(1'b0, 1'b0, tx_line_pkg::RATE_DS3);
    foreach (w[i]) term_framer_model_inst.send(w[i][1], w[i][0], 1'b0);
    repeat (20) @(negedge clk_sys);
    chk({7'h00, single_rail_active}, 8'h00);
    chk(8'(got.size()), 8'h07);
    foreach (w[i]) chk({6'h00, got[i]}, (w[i] == 2'h3) ? 8'h00 : {6'h00, w[i]});
  endtask

  // stalled shaper fills the buffer until it refuses, then it drains whole
  task automatic fill_run();
    do_reset(1'b0, 1'b0, tx_line_pkg::RATE_STS1);
    shaper_ready = 1'b0;
    for (int i = 0; i < 34; i++) term_framer_model_inst.send(1'b1, 1'b0, 1'b0);
    chk({7'h00, fifo_accept_ready}, 8'h00);
    shaper_ready = 1'b1;
    repeat (50) @(negedge clk_sys);
    chk(8'(got.size()), 8'h20);
    chk({6'h00, got[31]}, 8'h02);
  endtask

  // enable low freezes everything, so a link edge then is never taken
  task automatic ce_run();
    do_reset(1'b0, 1'b0, tx_line_pkg::RATE_DS3);
    ce = 1'b0;
    term_framer_model_inst.send(1'b1, 1'b0, 1'b0);
    repeat (10) @(negedge clk_sys);
    chk(8'(got.size()), 8'h00);
    ce = 1'b1;
    term_framer_model_inst.send(1'b0, 1'b1, 1'b0);
    repeat (10) @(negedge clk_sys);
    chk(8'(got.size()), 8'h01);
    chk({6'h00, got[0]}, 8'h01);
  endtask

  initial begin
    rst_n = 1'b0;
    rail_format_select = 1'b0;
    ctl_rail_bit0 = 1'b0;
    rate_sel = tx_line_pkg::RATE_DS3;
    shaper_ready = 1'b1;
    ce = 1'b1;
    failures = 0;
    num_checks = 0;
    cyc = 0;
    hi_n = 0;
    hi_last = 0;
    dual_run();
    single_run(1'b1, 1'b0, tx_line_pkg::RATE_DS3, 3);
    single_run(1'b0, 1'b1, tx_line_pkg::RATE_STS1, 3);
    single_run(1'b1, 1'b0, tx_line_pkg::RATE_E3, 4);
    fill_run();
    ce_run();
    conclude();
  end
endmodule
`default_nettype wire

// >>> hdl/tx_line_pkg.sv
package tx_line_pkg;
  // sampled pin vector layout
  localparam int SYNC_W = 7;
  localparam int PIN_CLK = 6;
  localparam int PIN_POS = 5;
  localparam int PIN_NEG = 4;
  localparam int PIN_FMT = 3;
  localparam int PIN_CTL = 2;
  localparam int PIN_RATE = 0;
  localparam logic [SYNC_W-1:0] SYNC_RST = 7'h00;

  // channel rate codes
  localparam logic [1:0] RATE_E3 = 2'h0;
  localparam logic [1:0] RATE_DS3 = 2'h1;
  localparam logic [1:0] RATE_STS1 = 2'h2;

  // nominal line rates in kHz (link clock is sampled, not used as a clock)
  localparam int RATE_E3_KHZ = 34368;
  localparam int RATE_DS3_KHZ = 44736;
  localparam int RATE_STS1_KHZ = 51840;
  localparam int CLK_SYS_KHZ = 10000;

  // substitution run lengths and symbol pipe depth
  localparam int RUN_B3ZS = 3;
  localparam int RUN_HDB3 = 4;
  localparam int PIPE_LEN = 4;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 2;

  // duty-restore period counter
  localparam int PER_W = 8;
  localparam logic [PER_W-1:0] PER_MAX = 8'hff;

  // pipe symbol codes
  typedef enum logic [1:0] {
    SYM_ZERO = 2'b00,
    SYM_MARK = 2'b01,
    SYM_BSUB = 2'b10,
    SYM_VIOL = 2'b11
  } sym_e;
endpackage

// >>> hdl/tx_rail_format_line_encoder.sv
`timescale 1ns/1ns
`default_nettype none

module sym_fifo #(
  parameter int WIDTH = tx_line_pkg::FIFO_WIDTH,
  parameter int DEPTH = tx_line_pkg::FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("sym_fifo depth must be a power of two >= 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = ce & in_valid & in_ready;
  assign pop = ce & out_valid & out_ready;

  // pointer and fill count
  always_comb begin
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    rd_nxt = pop ? rd_r + 1'b1 : rd_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage needs no reset; read only behind the count
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end
endmodule

module tx_rail_format_line_encoder (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // terminal equipment pins
  input wire logic line_tx_clock,
  input wire logic positive_rail_in,
  input wire logic negative_rail_in,
  // channel configuration pins
  input wire logic rail_format_select,
  input wire logic ctl_rail_bit0,
  input wire logic [1:0] rate_sel,
  // pulse shaper side
  input wire logic shaper_ready,
  output logic pulse_valid,
  output logic pos_pulse,
  output logic neg_pulse,
  output logic tx_clock_50,
  // status
  output logic fifo_accept_ready,
  output logic single_rail_active
);
  localparam int N = tx_line_pkg::SYNC_W;
  localparam int L = tx_line_pkg::PIPE_LEN;
  localparam int PW = tx_line_pkg::PER_W;

  // zero run for the substitution window, per rate
  function automatic int run_len(input logic [1:0] rate);
    return (rate == tx_line_pkg::RATE_E3) ? tx_line_pkg::RUN_HDB3 : tx_line_pkg::RUN_B3ZS;
  endfunction

  // ---- pin synchroniser: three stages, change taken when 2 and 3 agree
  logic [N-1:0] s1_r, s2_r, s3_r, flt_r, flt_nxt, prev_clk_r;
  logic [N-1:0] pin_vec;

  assign pin_vec = {line_tx_clock, positive_rail_in, negative_rail_in,
                    rail_format_select, ctl_rail_bit0, rate_sel};

  generate
    for (genvar i = 0; i < N; i++) begin : g_flt
      always_comb begin
        flt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : flt_r[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= tx_line_pkg::SYNC_RST;
      s2_r <= tx_line_pkg::SYNC_RST;
      s3_r <= tx_line_pkg::SYNC_RST;
      flt_r <= tx_line_pkg::SYNC_RST;
      prev_clk_r <= tx_line_pkg::SYNC_RST;
    end else if (ce) begin
      s1_r <= pin_vec;
      s2_r <= s1_r;
      s3_r <= s2_r;
      flt_r <= flt_nxt;
      prev_clk_r <= flt_r;
    end
  end

  logic clk_rise, single_rail;
  logic [1:0] rate;
  assign clk_rise = flt_r[tx_line_pkg::PIN_CLK] & ~prev_clk_r[tx_line_pkg::PIN_CLK];
  // either pin or control bit selects single rail
  assign single_rail = flt_r[tx_line_pkg::PIN_FMT] | flt_r[tx_line_pkg::PIN_CTL];
  assign rate = flt_r[tx_line_pkg::PIN_RATE +: 2];
  assign single_rail_active = single_rail;

  // 50% duty regeneration from measured period
  logic [PW-1:0] per_r, per_nxt, half_r, half_nxt;
  logic clk50_r, clk50_nxt;

  always_comb begin
    per_nxt = per_r;
    half_nxt = half_r;
    clk50_nxt = clk50_r;
    if (clk_rise) begin
      // any duty from 30% to 70% gives the same rising-edge period
      half_nxt = per_r >> 1;
      per_nxt = PW'(1);
      clk50_nxt = 1'b1;
    end else begin
      if (per_r != tx_line_pkg::PER_MAX) begin
        per_nxt = per_r + 1'b1;
      end
      if (per_r >= half_r) begin
        clk50_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      per_r <= '0;
      half_r <= '0;
      clk50_r <= 1'b0;
    end else if (ce) begin
      per_r <= per_nxt;
      half_r <= half_nxt;
      clk50_r <= clk50_nxt;
    end
  end
  assign tx_clock_50 = clk50_r;

  // ---- rail capture into fifo on each link clock rising edge while the fifo has room
  logic fifo_out_valid, pop;
  logic [1:0] fifo_out;

  sym_fifo #(
    .WIDTH(tx_line_pkg::FIFO_WIDTH),
    .DEPTH(tx_line_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(clk_rise),
    .in_ready(fifo_accept_ready),
    .in_data({flt_r[tx_line_pkg::PIN_POS], flt_r[tx_line_pkg::PIN_NEG]}),
    .out_valid(fifo_out_valid),
    .out_ready(shaper_ready),
    .out_data(fifo_out)
  );

  // shaper stalls the drain, so a slow shaper fills the fifo
  assign pop = ce & fifo_out_valid & shaper_ready;

  // ---- encoder: symbol pipe, parity since last violation, last polarity
  tx_line_pkg::sym_e pipe_r [L];
  tx_line_pkg::sym_e pipe_nxt [L];
  logic par_r, par_nxt, lastpos_r, lastpos_nxt;
  logic pos_r, pos_nxt, neg_r, neg_nxt, vld_r, vld_nxt;

  always_comb begin
    int run;
    logic all_zero;
    tx_line_pkg::sym_e out_sym;
    run = run_len(rate);
    all_zero = 1'b0;
    out_sym = pipe_r[L-1];
    pipe_nxt = pipe_r;
    par_nxt = par_r;
    lastpos_nxt = lastpos_r;
    pos_nxt = pos_r;
    neg_nxt = neg_r;
    vld_nxt = pop;
    if (pop) begin
      if (single_rail) begin
        // shift in new bit; fixed latency of the pipe length
        for (int k = L-1; k > 0; k--) begin
          pipe_nxt[k] = pipe_r[k-1];
        end
        pipe_nxt[0] = fifo_out[1] ? tx_line_pkg::SYM_MARK : tx_line_pkg::SYM_ZERO;
        all_zero = 1'b1;
        for (int k = 0; k < L; k++) begin
          if (k < run && pipe_nxt[k] != tx_line_pkg::SYM_ZERO) begin
            all_zero = 1'b0;
          end
        end
        if (all_zero) begin
          // even parity needs a b pulse to make the gap odd
          pipe_nxt[0] = tx_line_pkg::SYM_VIOL;
          if (!par_r) begin
            pipe_nxt[run-1] = tx_line_pkg::SYM_BSUB;
          end
          par_nxt = 1'b0;
        end else if (fifo_out[1]) begin
          par_nxt = ~par_r;
        end
        // polarity is given at the output end
        case (out_sym)
          tx_line_pkg::SYM_MARK, tx_line_pkg::SYM_BSUB: begin
            pos_nxt = ~lastpos_r;
            neg_nxt = lastpos_r;
            lastpos_nxt = ~lastpos_r;
          end
          tx_line_pkg::SYM_VIOL: begin
            pos_nxt = lastpos_r;
            neg_nxt = ~lastpos_r;
          end
          default: begin
            pos_nxt = 1'b0;
            neg_nxt = 1'b0;
          end
        endcase
      end else begin
        // encoder bypassed; both rails high is dropped
        for (int k = 0; k < L; k++) begin
          pipe_nxt[k] = tx_line_pkg::SYM_ZERO;
        end
        par_nxt = 1'b0;
        pos_nxt = fifo_out[1] & ~fifo_out[0];
        neg_nxt = fifo_out[0] & ~fifo_out[1];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < L; k++) begin
        pipe_r[k] <= tx_line_pkg::SYM_ZERO;
      end
      par_r <= 1'b0;
      lastpos_r <= 1'b0;
      pos_r <= 1'b0;
      neg_r <= 1'b0;
      vld_r <= 1'b0;
    end else if (ce) begin
      pipe_r <= pipe_nxt;
      par_r <= par_nxt;
      lastpos_r <= lastpos_nxt;
      pos_r <= pos_nxt;
      neg_r <= neg_nxt;
      vld_r <= vld_nxt;
    end
  end

  assign pos_pulse = pos_r;
  assign neg_pulse = neg_r;
  assign pulse_valid = vld_r;
endmodule

`default_nettype wire
